//--- readout_defs.svh
`ifndef READOUT_DEFS_SVH
`define READOUT_DEFS_SVH

// Bank geometry
`define RES_REG_COUNT     4
`define RES_WIDTH         12
`define RES_PTR_WIDTH     2
`define RES_CNT_WIDTH     3
// Pointer value that addresses register 1
`define RES_PTR_FIRST     2'h0
// Bus value while not driving
`define RES_BUS_IDLE      12'h000
// Buffer depth in front of the bank
`define RES_FIFO_DEPTH    8
// Synchroniser length for host pins
`define PIN_SYNC_STAGES   3

`endif

//--- readout_pkg.sv
package readout_pkg;

   // One conversion result as it lands from the converter core
   typedef struct packed {
      logic [11:0] code;  // Two's complement for bipolar ranges
      logic        first; // First conversion of the sequence
   } conv_result_t;

   // Host strobes after the synchroniser
   typedef struct packed {
      logic sel_n;
      logic rd_n;
   } host_strobe_t;

   // Whether the sequence is still running
   typedef enum logic [0:0] {
      PH_CONVERTING = 1'b1,
      PH_DONE       = 1'b0
   } seq_phase_t;

endpackage

//--- result_fifo.sv
// The result buffer module sits beside the readout logic in one design file

//--- result_register_readout.sv
`timescale 1ns/1ps
`include "readout_defs.svh"

module result_register_readout #(
   parameter int REG_COUNT = `RES_REG_COUNT,
   parameter int DEPTH     = `RES_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rstn_i,
   // Results from the converter core
   input  wire logic                         res_valid_i,
   output      logic                         res_ready_o,
   input  wire readout_pkg::conv_result_t    res_i,
   // Sequence control from the converter core
   input  wire logic                         seq_start_i,
   input  wire logic [`RES_CNT_WIDTH-1:0]    seq_count_i,
   input  wire logic                         seq_end_i,
   // Host pins
   input  wire logic                         sel_n_i,
   input  wire logic                         rd_n_i,
   output      logic [`RES_WIDTH-1:0]        result_bus_o,
   output      logic                         result_bus_oe_o,
   // Status pins
   output      logic                         first_result_flag_o,
   output      logic                         busy_o,
   output      logic                         conv_done_n_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Host pin synchronisers

   logic [`PIN_SYNC_STAGES-1:0] sel_sync_r;
   logic [`PIN_SYNC_STAGES-1:0] rd_sync_r;
   readout_pkg::host_strobe_t   strobe_r;

   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sel_sync_r <= '1;
         rd_sync_r  <= '1;
      end else begin
         sel_sync_r <= {sel_sync_r[`PIN_SYNC_STAGES-2:0], sel_n_i};
         rd_sync_r  <= {rd_sync_r[`PIN_SYNC_STAGES-2:0], rd_n_i};
      end
   end

   // Filtered strobes follow only when the last two stages agree
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         strobe_r <= '{sel_n: 1'b1, rd_n: 1'b1};
      end else begin
         if (sel_sync_r[`PIN_SYNC_STAGES-2] == sel_sync_r[`PIN_SYNC_STAGES-1]) begin
            strobe_r.sel_n <= sel_sync_r[`PIN_SYNC_STAGES-1];
         end
         if (rd_sync_r[`PIN_SYNC_STAGES-2] == rd_sync_r[`PIN_SYNC_STAGES-1]) begin
            strobe_r.rd_n <= rd_sync_r[`PIN_SYNC_STAGES-1];
         end
      end
   end

   logic rd_rise;
   logic read_active;
   assign read_active = !strobe_r.sel_n && !strobe_r.rd_n;
   assign rd_rise     = !strobe_r.rd_n && !strobe_r.sel_n
                        && (rd_sync_r[`PIN_SYNC_STAGES-2] == rd_sync_r[`PIN_SYNC_STAGES-1])
                        && rd_sync_r[`PIN_SYNC_STAGES-1];

   ////////////////////////////////////////////////////////////////////////////////
   // Result buffer in front of the bank

   readout_pkg::conv_result_t fifo_out;
   logic                      fifo_valid;
   logic                      fifo_ready;

   result_fifo #(
      .WIDTH ($bits(readout_pkg::conv_result_t)),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rstn_i      (rstn_i),
      .in_valid_i  (res_valid_i),
      .in_ready_o  (res_ready_o),
      .in_data_i   (res_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_ready),
      .out_data_o  (fifo_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Sequence state

   readout_pkg::seq_phase_t          phase_r;
   logic [`RES_CNT_WIDTH-1:0]        last_cnt_r;   // Channels in this sequence
   logic [`RES_CNT_WIDTH-1:0]        filled_r;     // Results landed so far
   logic                             land;
   logic                             done_pulse_r;
   logic                             end_pend_r;   // Core has reported the end

   // At most one result lands every two cycles; stalls while a done strobe is still low
   assign fifo_ready = !done_pulse_r;
   assign land       = fifo_valid && fifo_ready;

   // Busy runs from start to the end of the whole sequence
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase_r    <= readout_pkg::PH_DONE;
         last_cnt_r <= `RES_CNT_WIDTH'(REG_COUNT);
      end else if (seq_start_i) begin
         phase_r    <= readout_pkg::PH_CONVERTING;
         last_cnt_r <= (seq_count_i == '0) ? `RES_CNT_WIDTH'(1) : seq_count_i;
      end else if ((seq_end_i || end_pend_r) && !fifo_valid && !land) begin
         phase_r    <= readout_pkg::PH_DONE; // Low only once all results landed
      end
   end

   // A short end report is kept until the next start, so busy cannot stick high
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         end_pend_r <= 1'b0;
      end else if (seq_start_i) begin
         end_pend_r <= 1'b0;
      end else if (seq_end_i) begin
         end_pend_r <= 1'b1;
      end
   end

   assign busy_o = (phase_r == readout_pkg::PH_CONVERTING);

   // Low-going done strobe, one cycle after each result lands
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         done_pulse_r <= 1'b0;
      end else begin
         done_pulse_r <= land;
      end
   end

   assign conv_done_n_o = !done_pulse_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Result bank, four registers indexed by landing order

   logic [`RES_WIDTH-1:0] bank_r [REG_COUNT];

   // Results fill registers upward from the first, no gaps
   always_ff @(posedge clk_i) begin
      if (land) begin
         bank_r[fifo_out.first ? `RES_PTR_FIRST : filled_r[`RES_PTR_WIDTH-1:0]]
            <= fifo_out.code; // Code passed through unchanged
      end
   end

   // Landing count, restarted by the first conversion
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         filled_r <= '0;
      end else if (land) begin
         filled_r <= fifo_out.first ? `RES_CNT_WIDTH'(1) : filled_r + 1'b1;
      end else if (seq_start_i) begin
         filled_r <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read pointer

   logic [`RES_PTR_WIDTH-1:0] ptr_r;
   logic [`RES_CNT_WIDTH-1:0] ptr_plus;
   logic                      next_ready;
   logic                      at_last;
   logic                      rd_pend_r;   // Read edge waiting for its result

   assign ptr_plus   = {1'b0, ptr_r} + `RES_CNT_WIDTH'(1);
   assign at_last    = (ptr_plus >= last_cnt_r);
   assign next_ready = (ptr_plus < filled_r);

   // Landing wins; a read edge in the landing cycle is served by that landing
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ptr_r <= `RES_PTR_FIRST;
      end else if (land && fifo_out.first) begin
         ptr_r <= `RES_PTR_FIRST;
      end else if (land && filled_r > `RES_CNT_WIDTH'(0)
                   && busy_o && (ptr_plus == filled_r) && (rd_pend_r || rd_rise)) begin
         ptr_r <= ptr_r + 1'b1; // Held read advances as result lands
      end else if (rd_rise && at_last && (!busy_o || filled_r == last_cnt_r)) begin
         ptr_r <= `RES_PTR_FIRST; // Circular wrap
      end else if (rd_rise && (!busy_o || next_ready)) begin
         ptr_r <= ptr_r + 1'b1;
      end
   end

   // A read edge that found no next result waits for it to land
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_pend_r <= 1'b0;
      end else if (land) begin
         rd_pend_r <= 1'b0;
      end else if (rd_rise && busy_o && !next_ready && !at_last) begin
         rd_pend_r <= 1'b1;
      end
   end

   // Flag tracks whether register 1 is addressed and at least one result has landed
   assign first_result_flag_o = (ptr_r == `RES_PTR_FIRST) && (filled_r != '0);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus drive

   // Registered so the pins never see a decode glitch
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         result_bus_o    <= `RES_BUS_IDLE;
         result_bus_oe_o <= 1'b0;
      end else begin
         result_bus_o    <= read_active ? bank_r[ptr_r] : `RES_BUS_IDLE;
         result_bus_oe_o <= read_active;
      end
   end

endmodule

////////////////////////////////////////////////////////////////////////////////
// Result buffer, valid and ready on both sides

module result_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = `RES_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rstn_i,
   // Fill side
   input  wire logic             in_valid_i,
   output      logic             in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output      logic             out_valid_o,
   input  wire logic             out_ready_i,
   output      logic [WIDTH-1:0] out_data_o
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   // Handshakes; full and empty from the occupancy count
   assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
   assign out_valid_o = (count_r != '0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem_r[rd_ptr_r];

   // Storage, no reset needed on data
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   // Pointers wrap at DEPTH, which need not be a power of two
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
      end
   end

   // Occupancy
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         count_r <= '0;
      end else if (push && !pop) begin
         count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
         count_r <= count_r - 1'b1;
      end
   end

endmodule

//--- readout_checker.sv
`timescale 1ns/1ps
`include "readout_defs.svh"

module readout_checker #(
   parameter int REG_COUNT = `RES_REG_COUNT,
   parameter int DEPTH     = `RES_FIFO_DEPTH
) (
   input wire logic                  clk_i,
   input wire logic                  rstn_i,
   input wire logic                  seq_start_i,
   input wire logic                  seq_end_i,
   input wire logic                  sel_n_i,
   input wire logic                  rd_n_i,
   input wire logic [`RES_WIDTH-1:0] result_bus_o,
   input wire logic                  result_bus_oe_o,
   input wire logic                  first_result_flag_o,
   input wire logic                  busy_o,
   input wire logic                  conv_done_n_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   // Busy may only fall once the core has reported the end
   logic end_seen_r;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) end_seen_r <= 1'b0;
      else if (seq_start_i) end_seen_r <= 1'b0;
      else if (seq_end_i) end_seen_r <= 1'b1;
   end

   a_bus_idle_zero: assert property (!result_bus_oe_o |-> result_bus_o == 12'h000)
      else $error("bus not zero while idle");
   a_oe_has_cause: assert property ($rose(result_bus_oe_o) |-> $past(!sel_n_i && !rd_n_i, 2))
      else $error("bus driven without select and read");
   a_oe_follows_pins: assert property ((!sel_n_i && !rd_n_i) [*6] |-> result_bus_oe_o)
      else $error("bus not driven during read");
   a_oe_released: assert property (sel_n_i [*6] |-> !result_bus_oe_o)
      else $error("bus driven while deselected");
   a_done_one_cycle: assert property ($fell(conv_done_n_o) |=> conv_done_n_o)
      else $error("done strobe longer than one cycle");
   a_busy_on_start: assert property (seq_start_i |=> busy_o)
      else $error("busy not raised by start");
   a_busy_after_end: assert property ($fell(busy_o) |-> end_seen_r)
      else $error("busy fell before end");
   a_flag_drop_read: assert property (!busy_o && $fell(first_result_flag_o) |-> $past(rd_n_i, 3))
      else $error("flag fell without read edge");
   a_bus_steady_done: assert property (!busy_o && $past(!busy_o) && result_bus_oe_o
      && $past(result_bus_oe_o) |-> $stable(result_bus_o))
      else $error("bus changed within a read");

   c_read: cover property ($rose(result_bus_oe_o));
   c_done: cover property ($fell(conv_done_n_o));
   c_wrap: cover property (!busy_o && $rose(first_result_flag_o));
   c_held_read: cover property (busy_o && $fell(first_result_flag_o));
endmodule

bind result_register_readout readout_checker #(.REG_COUNT(REG_COUNT), .DEPTH(DEPTH)) chk_inst (
   .clk_i(clk_i), .rstn_i(rstn_i), .seq_start_i(seq_start_i), .seq_end_i(seq_end_i),
   .sel_n_i(sel_n_i), .rd_n_i(rd_n_i), .result_bus_o(result_bus_o),
   .result_bus_oe_o(result_bus_oe_o), .first_result_flag_o(first_result_flag_o),
   .busy_o(busy_o), .conv_done_n_o(conv_done_n_o));

//--- readout_host.sv
`timescale 1ns/1ps

module readout_host (
   // Clock
   input  wire logic        clk_i,
   // Host strobes and bus
   output      logic        sel_n_o,
   output      logic        rd_n_o,
   input  wire logic [11:0] bus_i,
   input  wire logic        oe_i
);
   initial begin
      sel_n_o = 1'b1;
      rd_n_o  = 1'b1;
   end

   // One read; select stays low past the rising read edge so the pointer moves
   task automatic read_word(input int hold, output logic [11:0] d, output logic oe);
      @(posedge clk_i);
      sel_n_o <= 1'b0;
      rd_n_o  <= 1'b0;
      repeat (hold) @(posedge clk_i);
      #1;
      d  = bus_i;
      oe = oe_i;
      @(posedge clk_i);
      rd_n_o <= 1'b1;
      repeat (5) @(posedge clk_i);
      sel_n_o <= 1'b1;
      repeat (5) @(posedge clk_i);
   endtask
endmodule

//--- tb.sv
`timescale 1ns/1ps

module tb;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic res_valid_i = 1'b0;
   logic res_ready_o;
   readout_pkg::conv_result_t res_i = '0;
   logic seq_start_i = 1'b0;
   logic [2:0] seq_count_i = 3'h0;
   logic seq_end_i = 1'b0;
   logic sel_n_i;
   logic rd_n_i;
   logic [11:0] result_bus_o;
   logic result_bus_oe_o;
   logic first_result_flag_o;
   logic busy_o;
   logic conv_done_n_o;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [11:0] d;
   logic oe;

   result_register_readout result_register_readout_inst (
      .clk_i               (clk_i),
      .rstn_i              (rstn_i),
      .res_valid_i         (res_valid_i),
      .res_ready_o         (res_ready_o),
      .res_i               (res_i),
      .seq_start_i         (seq_start_i),
      .seq_count_i         (seq_count_i),
      .seq_end_i           (seq_end_i),
      .sel_n_i             (sel_n_i),
      .rd_n_i              (rd_n_i),
      .result_bus_o        (result_bus_o),
      .result_bus_oe_o     (result_bus_oe_o),
      .first_result_flag_o (first_result_flag_o),
      .busy_o              (busy_o),
      .conv_done_n_o       (conv_done_n_o)
   );
   readout_host readout_host_inst (.clk_i(clk_i), .sel_n_o(sel_n_i), .rd_n_o(rd_n_i),
      .bus_i(result_bus_o), .oe_i(result_bus_oe_o));

   initial begin
      forever #10 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // A hang must still reach the report
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         summarize();
      end
   end

   // Hold the result until the buffer accepts it
   task automatic send(input logic [11:0] code, input logic first);
      @(posedge clk_i);
      res_valid_i <= 1'b1;
      res_i <= '{code: code, first: first};
      do @(posedge clk_i); while (res_ready_o !== 1'b1);
      res_valid_i <= 1'b0;
      @(posedge clk_i);
      #1 chk("done", 12'(conv_done_n_o), 12'h000);
      repeat (7) @(posedge clk_i);
   endtask

   task automatic start(input logic [2:0] n);
      @(posedge clk_i);
      seq_start_i <= 1'b1;
      seq_count_i <= n;
      @(posedge clk_i);
      seq_start_i <= 1'b0;
   endtask

   task automatic finish_seq();
      chk("busy", 12'(busy_o), 12'h001);
      @(posedge clk_i);
      seq_end_i <= 1'b1;
      @(posedge clk_i);
      seq_end_i <= 1'b0;
      repeat (60) @(posedge clk_i);
      #1 chk("busy", 12'(busy_o), 12'h000);
   endtask

   task automatic rd(input int hold, input logic [11:0] exp);
      readout_host_inst.read_word(hold, d, oe);
      chk("bus", d, exp);
      chk("oe", 12'(oe), 12'h001);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Three results read after the sequence, full scale codes, wrap at count
   task automatic t_after();
      start(3'h3);
      send(12'h7FF, 1'b1);
      send(12'h800, 1'b0);
      send(12'h123, 1'b0);
      finish_seq();
      chk("flag", 12'(first_result_flag_o), 12'h001);
      rd(5, 12'h7FF);
      chk("flag", 12'(first_result_flag_o), 12'h000);
      rd(9, 12'h800);
      rd(5, 12'h123);
      chk("flag", 12'(first_result_flag_o), 12'h001);
      rd(5, 12'h7FF);
      #1 chk("idle", result_bus_o, 12'h000);
   endtask

   // Read during the sequence: the edge waits for the next result to land
   task automatic t_during();
      start(3'h2);
      send(12'h456, 1'b1);
      rd(5, 12'h456);
      chk("flag", 12'(first_result_flag_o), 12'h001);
      send(12'h789, 1'b0);
      chk("flag", 12'(first_result_flag_o), 12'h000);
      finish_seq();
      rd(5, 12'h789);
      chk("flag", 12'(first_result_flag_o), 12'h001);
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      #1 chk("busy", 12'(busy_o), 12'h000);
      chk("done", 12'(conv_done_n_o), 12'h001);
      chk("oe", 12'(result_bus_oe_o), 12'h000);
      chk("ready", 12'(res_ready_o), 12'h001);
      chk("flag", 12'(first_result_flag_o), 12'h000);
      // All results of one sequence are read before the next starts
      t_after();
      t_during();
      summarize();
   end
endmodule
